// ==== verilog/poc_cfg.svh ====
// Register offsets, reset values, field positions and ramp timing figures
// for the PWM output control block. Definitions only.
`ifndef POC_CFG_SVH
`define POC_CFG_SVH

// Register offsets on the serial control port
`define POC_ADDR_VOL_RAMP 8'h0e
`define POC_ADDR_MOD_LIMIT 8'h10
`define POC_ADDR_DLY_CH1 8'h11
`define POC_ADDR_DLY_CH2 8'h12
`define POC_ADDR_DLY_CH1_INV 8'h13
`define POC_ADDR_DLY_CH2_INV 8'h14
`define POC_ADDR_STOP_GROUP 8'h19

// Reset values
`define POC_RST_SLEW 3'h0
`define POC_RST_MOD_LIMIT 3'h2
`define POC_RST_DLY_CH1 8'hac
`define POC_RST_DLY_CH2 8'h54
`define POC_RST_STOP_GROUP 8'h30

// Field positions
`define POC_SLEW_MSB 2
`define POC_SLEW_RSVD_BIT 2
`define POC_MODLIM_MSB 2
`define POC_DLY_MSB 7
`define POC_DLY_LSB 2
`define POC_GROUP_MSB 3

// Slew codes
`define POC_SLEW_512 2'h0
`define POC_SLEW_1024 2'h1
`define POC_SLEW_2048 2'h2
`define POC_SLEW_256 2'h3

// Modulation ceiling in 1/256 of full scale: base minus two per code
`define POC_MODLIM_BASE 8'hfe

// Ramp step interval per sample-rate family, in ns, and clock rate
`define POC_STEP_NS_8K 125000
`define POC_STEP_NS_11K 90700
`define POC_STEP_NS_12K 83300
`define POC_CLK_MHZ 200

`endif

// ==== verilog/poc_pkg.sv ====
// Types shared by the PWM output control block and its bench.
// Assumes poc_cfg.svh supplies every number.
package poc_pkg;

  typedef enum logic [1:0] {
    POC_FAM_8K = 2'b00,
    POC_FAM_11K = 2'b01,
    POC_FAM_12K = 2'b10
  } poc_rate_fam_t;

  typedef enum logic [0:0] {
    POC_RAMP_IDLE = 1'b0,
    POC_RAMP_RUN = 1'b1
  } poc_ramp_st_t;

  // Per-channel delay in pwm_delay_clock cycles, two's complement
  typedef struct packed {
    logic [8:0] ch1;
    logic [8:0] ch2;
    logic [8:0] ch1_inv;
    logic [8:0] ch2_inv;
  } poc_delay_t;

endpackage

// ==== verilog/poc_regs.sv ====
// PWM output control settings: volume ramp, modulation ceiling,
// interchannel delays and stop group, written over the control port.
// Assumes control port decode, sample-rate family and shutdown requests
// all come from logic on clk.
`timescale 1ns/1ps
`include "poc_cfg.svh"

module poc_regs #(
  parameter int STEP_CYC_8K = (`POC_STEP_NS_8K * `POC_CLK_MHZ) / 1000,
  parameter int STEP_CYC_11K = (`POC_STEP_NS_11K * `POC_CLK_MHZ) / 1000,
  parameter int STEP_CYC_12K = (`POC_STEP_NS_12K * `POC_CLK_MHZ) / 1000,
  parameter int GAIN_W = 10
) (
  input wire logic clk, // 200 MHz PWM processor clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [7:0] reg_addr, // Register subaddress
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_rd, // Read strobe, one cycle
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, valid cycle after strobe
  input wire poc_pkg::poc_rate_fam_t rate_fam, // Sample-rate family
  input wire logic [GAIN_W-1:0] vol_target, // Requested volume code
  output logic [GAIN_W-1:0] gain_applied, // Ramped volume code
  output logic ramp_busy, // High while ramping
  output logic [7:0] mod_limit, // Duty ceiling, 1/256 units
  output poc_pkg::poc_delay_t chan_delay, // Delays in delay clocks
  input wire logic all_shutdown, // All-channel shutdown request
  input wire logic group_qualify, // System control stop group qualifier
  output logic [3:0] chan_run // Channel 4..1 running
);

  localparam int FRAC_W = 11;
  localparam int ACC_W = GAIN_W + FRAC_W;

  // ************************************************************
  // Register file
  // ************************************************************
  logic [2:0] slew_r, slew_nxt;
  logic [2:0] modlim_r, modlim_nxt;
  logic [5:0] dly_r [4];
  logic [5:0] dly_nxt [4];
  logic [7:0] group_r, group_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  always_comb begin
    slew_nxt = slew_r;
    modlim_nxt = modlim_r;
    dly_nxt = dly_r;
    group_nxt = group_r;
    rdata_nxt = rdata_r;
    if (reg_wr) begin
      if (reg_addr == `POC_ADDR_VOL_RAMP) begin
        slew_nxt = reg_wdata[`POC_SLEW_MSB:0];
      end else if (reg_addr == `POC_ADDR_MOD_LIMIT) begin
        modlim_nxt = reg_wdata[`POC_MODLIM_MSB:0];
      end else if (reg_addr == `POC_ADDR_DLY_CH1) begin
        dly_nxt[0] = reg_wdata[`POC_DLY_MSB:`POC_DLY_LSB];
      end else if (reg_addr == `POC_ADDR_DLY_CH2) begin
        dly_nxt[1] = reg_wdata[`POC_DLY_MSB:`POC_DLY_LSB];
      end else if (reg_addr == `POC_ADDR_DLY_CH1_INV) begin
        dly_nxt[2] = reg_wdata[`POC_DLY_MSB:`POC_DLY_LSB];
      end else if (reg_addr == `POC_ADDR_DLY_CH2_INV) begin
        dly_nxt[3] = reg_wdata[`POC_DLY_MSB:`POC_DLY_LSB];
      end else if (reg_addr == `POC_ADDR_STOP_GROUP) begin
        group_nxt = reg_wdata;
      end
    end
    if (reg_rd) begin
      // Unmapped subaddresses and unused bits read as zero; the reserved slew bit and stop group bits 7:4 read back as written
      if (reg_addr == `POC_ADDR_VOL_RAMP) begin
        rdata_nxt = {5'h00, slew_r};
      end else if (reg_addr == `POC_ADDR_MOD_LIMIT) begin
        rdata_nxt = {5'h00, modlim_r};
      end else if (reg_addr == `POC_ADDR_DLY_CH1) begin
        rdata_nxt = {dly_r[0], 2'h0};
      end else if (reg_addr == `POC_ADDR_DLY_CH2) begin
        rdata_nxt = {dly_r[1], 2'h0};
      end else if (reg_addr == `POC_ADDR_DLY_CH1_INV) begin
        rdata_nxt = {dly_r[2], 2'h0};
      end else if (reg_addr == `POC_ADDR_DLY_CH2_INV) begin
        rdata_nxt = {dly_r[3], 2'h0};
      end else if (reg_addr == `POC_ADDR_STOP_GROUP) begin
        rdata_nxt = group_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slew_r <= `POC_RST_SLEW;
      modlim_r <= `POC_RST_MOD_LIMIT;
      dly_r[0] <= 6'(`POC_RST_DLY_CH1 >> `POC_DLY_LSB);
      dly_r[1] <= 6'(`POC_RST_DLY_CH2 >> `POC_DLY_LSB);
      dly_r[2] <= 6'(`POC_RST_DLY_CH1 >> `POC_DLY_LSB);
      dly_r[3] <= 6'(`POC_RST_DLY_CH2 >> `POC_DLY_LSB);
      group_r <= `POC_RST_STOP_GROUP;
      rdata_r <= 8'h00;
    end else if (ce) begin
      slew_r <= slew_nxt;
      modlim_r <= modlim_nxt;
      dly_r <= dly_nxt;
      group_r <= group_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ************************************************************
  // Derived outputs: ceiling, delays, channel run
  // ************************************************************
  logic [7:0] modmax_r, modmax_nxt;
  poc_pkg::poc_delay_t delay_r, delay_nxt;
  logic [3:0] run_r, run_nxt;
  logic shut_d_r, shut_d_nxt;

  always_comb begin
    // 254 - 2*code gives 99.2% .. 93.8% in 2/256 steps
    modmax_nxt = `POC_MODLIM_BASE - {4'h0, modlim_r, 1'b0};
    // Sign-extended field times four
    delay_nxt.ch1 = {dly_r[0][5], dly_r[0], 2'h0};
    delay_nxt.ch2 = {dly_r[1][5], dly_r[1], 2'h0};
    delay_nxt.ch1_inv = {dly_r[2][5], dly_r[2], 2'h0};
    delay_nxt.ch2_inv = {dly_r[3][5], dly_r[3], 2'h0};
    shut_d_nxt = all_shutdown;
    run_nxt = run_r;
    if (all_shutdown) begin
      run_nxt = 4'h0;
    end else if (shut_d_r) begin
      // Membership latched only at exit; later writes wait for next exit
      if (!group_qualify) begin
        run_nxt = ~group_r[`POC_GROUP_MSB:0];
      end else begin
        run_nxt = 4'hf;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      modmax_r <= 8'h00;
      delay_r <= '0;
      run_r <= 4'h0;
      shut_d_r <= 1'b1;
    end else if (ce) begin
      modmax_r <= modmax_nxt;
      delay_r <= delay_nxt;
      run_r <= run_nxt;
      shut_d_r <= shut_d_nxt;
    end
  end

  assign mod_limit = modmax_r;
  assign chan_delay = delay_r;
  assign chan_run = run_r;

  // ************************************************************
  // Ramp step timer
  // ************************************************************
  logic [14:0] tick_cnt_r, tick_cnt_nxt;
  logic [14:0] tick_lim;
  logic tick;

  always_comb begin
    case (rate_fam)
      poc_pkg::POC_FAM_11K: tick_lim = 15'(STEP_CYC_11K - 1);
      poc_pkg::POC_FAM_12K: tick_lim = 15'(STEP_CYC_12K - 1);
      default: tick_lim = 15'(STEP_CYC_8K - 1);
    endcase
    tick = (tick_cnt_r >= tick_lim);
    tick_cnt_nxt = tick ? 15'h0000 : tick_cnt_r + 15'h0001;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_r <= 15'h0000;
    end else if (ce) begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // ************************************************************
  // Volume ramp
  // ************************************************************
  poc_pkg::poc_ramp_st_t st_r, st_nxt;
  logic [ACC_W:0] acc_r, acc_nxt;
  logic [ACC_W:0] step_r, step_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic [11:0] steps_r, steps_nxt;
  logic [GAIN_W-1:0] goal_r, goal_nxt;
  logic [GAIN_W:0] diff;
  logic [ACC_W:0] diff_ext;
  logic [1:0] shamt;
  logic [11:0] nsteps;

  always_comb begin
    // Reserved 1xx codes fall back to the 512-step default
    if (slew_r[`POC_SLEW_RSVD_BIT]) begin
      shamt = 2'h2;
    end else begin
      case (slew_r[1:0])
        `POC_SLEW_1024: shamt = 2'h1;
        `POC_SLEW_2048: shamt = 2'h0;
        `POC_SLEW_256: shamt = 2'h3;
        default: shamt = 2'h2;
      endcase
    end
    // Step count is 2048 shifted down by the same amount
    nsteps = 12'h800 >> shamt;
    diff = {1'b0, vol_target} - {1'b0, acc_r[ACC_W-1:FRAC_W]};
    diff_ext = {{FRAC_W{diff[GAIN_W]}}, diff};
    st_nxt = st_r;
    acc_nxt = acc_r;
    step_nxt = step_r;
    cnt_nxt = cnt_r;
    steps_nxt = steps_r;
    goal_nxt = goal_r;
    case (st_r)
      poc_pkg::POC_RAMP_IDLE: begin
        if (vol_target != acc_r[ACC_W-1:FRAC_W]) begin
          // Step is diff * 2^11 / steps; steps are powers of two
          step_nxt = diff_ext << shamt;
          steps_nxt = nsteps;
          goal_nxt = vol_target;
          cnt_nxt = 12'h000;
          st_nxt = poc_pkg::POC_RAMP_RUN;
        end
      end
      poc_pkg::POC_RAMP_RUN: begin
        if (tick) begin
          cnt_nxt = cnt_r + 12'h001;
          if (cnt_nxt == steps_r) begin
            acc_nxt = {1'b0, goal_r, {FRAC_W{1'b0}}};
            st_nxt = poc_pkg::POC_RAMP_IDLE;
          end else begin
            acc_nxt = acc_r + step_r;
          end
        end
      end
      default: st_nxt = poc_pkg::POC_RAMP_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= poc_pkg::POC_RAMP_IDLE;
      acc_r <= '0;
      step_r <= '0;
      cnt_r <= 12'h000;
      steps_r <= 12'h200;
      goal_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
      acc_r <= acc_nxt;
      step_r <= step_nxt;
      cnt_r <= cnt_nxt;
      steps_r <= steps_nxt;
      goal_r <= goal_nxt;
    end
  end

  assign gain_applied = acc_r[ACC_W-1:FRAC_W];
  assign ramp_busy = (st_r == poc_pkg::POC_RAMP_RUN);

endmodule

// ==== bench/poc_stage_model.sv ====
// Power stage stand-in: a bridge half switches only while its channel runs.
// Assumes chan_run comes from poc_regs on the same clock.
`timescale 1ns/1ps
module poc_stage_model (
  input wire logic clk, // 200 MHz clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic [3:0] chan_run, // Channels allowed to switch
  output logic [3:0] stage_on // Bridge halves switching
);
  // One flop of gate-driver latency, as a real stage would add
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) stage_on <= 4'h0;
    else stage_on <= chan_run;
  end
endmodule

// ==== bench/poc_regs_properties.sv ====
// Port checks for poc_regs.
// Assumes the bench holds vol_target steady while a ramp runs.
`timescale 1ns/1ps
`include "poc_cfg.svh"
module poc_regs_properties #(
  parameter int GAIN_W = 10
) (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic ce, // Enable
  input wire logic [7:0] reg_addr, // Address
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic [GAIN_W-1:0] vol_target, // Target
  input wire logic [GAIN_W-1:0] gain_applied, // Gain
  input wire logic ramp_busy, // Ramping
  input wire logic [7:0] mod_limit, // Ceiling
  input wire poc_pkg::poc_delay_t chan_delay, // Delays
  input wire logic all_shutdown, // Shutdown
  input wire logic group_qualify, // Qualifier
  input wire logic [3:0] chan_run // Running
);
  logic w11;
  logic w14;
  logic w10;
  assign w11 = ce && reg_wr && reg_addr == `POC_ADDR_DLY_CH1;
  assign w14 = ce && reg_wr && reg_addr == `POC_ADDR_DLY_CH2_INV;
  assign w10 = ce && reg_wr && reg_addr == `POC_ADDR_MOD_LIMIT;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  unmapped_read_a: assert property (ce && reg_rd && !(reg_addr inside
    {8'h0e, 8'h10, [8'h11:8'h14], 8'h19}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  delay_one_a: assert property (w11 ##1 (ce && !w11) |=>
    chan_delay.ch1 == {$past(reg_wdata[7], 2), $past(reg_wdata[7:2], 2),
    2'b00}) else $error("channel one delay wrong");
  delay_map_a: assert property (w14 ##1 (ce && !w14) |=>
    chan_delay.ch2_inv[8:2] ==
    {$past(reg_wdata[7], 2), $past(reg_wdata[7:2], 2)})
    else $error("inverted channel two delay wrong");
  mod_ceiling_a: assert property (w10 ##1 (ce && !w10) |=>
    mod_limit == 8'hfe - {4'h0, $past(reg_wdata[2:0], 2), 1'b0})
    else $error("modulation ceiling wrong");
  stop_all_a: assert property (ce && all_shutdown |=> chan_run == 4'h0)
    else $error("channel runs in shutdown");
  exit_qual_a: assert property (ce && $fell(all_shutdown) &&
    group_qualify |-> ##[1:2] chan_run == 4'hf)
    else $error("qualified exit wrong");
  ramp_start_a: assert property (ce && !ramp_busy &&
    vol_target != gain_applied |=> ramp_busy) else $error("ramp not started");
  ramp_end_a: assert property ($fell(ramp_busy) |->
    gain_applied == vol_target) else $error("ramp ended off target");
  ramp_min_a: assert property ($rose(ramp_busy) |-> ramp_busy[*8])
    else $error("ramp too short");
  state_freeze_a: assert property (!ce |=> $stable(gain_applied) &&
    $stable(chan_run) && $stable(reg_rdata))
    else $error("state moved with ce low");
endmodule
bind poc_regs poc_regs_properties #(.GAIN_W(GAIN_W)) i_poc_regs_properties (
  .clk, .sys_rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .vol_target, .gain_applied, .ramp_busy, .mod_limit, .chan_delay,
  .all_shutdown, .group_qualify, .chan_run);

// ==== bench/tb_poc_regs.sv ====
// Self-checking bench for poc_regs with a power stage stand-in.
// Assumes short step intervals of 4, 3 and 2 clocks per rate family.
`timescale 1ns/1ps
`include "poc_cfg.svh"
module tb_poc_regs;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  poc_pkg::poc_rate_fam_t rate_fam = poc_pkg::POC_FAM_8K;
  logic [9:0] vol_target = 10'h000;
  logic [9:0] gain_applied;
  logic ramp_busy;
  logic [7:0] mod_limit;
  poc_pkg::poc_delay_t chan_delay;
  logic all_shutdown = 1'b0;
  logic group_qualify = 1'b0;
  logic [3:0] chan_run;
  logic [3:0] stage_on;
  int errors = 0;
  int total_checks = 0;
  always #2.5 clk = ~clk;
  poc_regs #(.STEP_CYC_8K(4), .STEP_CYC_11K(3), .STEP_CYC_12K(2)) i_poc_regs (
    .clk, .sys_rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .rate_fam, .vol_target, .gain_applied, .ramp_busy, .mod_limit,
    .chan_delay, .all_shutdown, .group_qualify, .chan_run);
  poc_stage_model i_poc_stage_model (.clk, .sys_rst, .chan_run, .stage_on);
  task automatic chk(input string what, input logic [35:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    chk("reg_rdata", reg_rdata, exp);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_reset();
    logic [7:0] a [8] = '{8'h0e, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
      8'h19, 8'h15};
    logic [7:0] e [8] = '{8'h00, 8'h02, 8'hac, 8'h54, 8'hac, 8'h54,
      8'h30, 8'h00};
    for (int i = 0; i < 8; i++) rd_chk(a[i], e[i]);
    chk("mod_limit", mod_limit, 8'hfa);
    chk("chan_delay", chan_delay, {2{9'h1ac, 9'h054}});
    chk("chan_run", chan_run, 4'hf);
    $display("reset test done");
  endtask
  task automatic t_delay();
    logic [7:0] v [8] = '{8'hb8, 8'h60, 8'ha0, 8'h48, 8'h7c, 8'h80,
      8'h03, 8'hfc};
    for (int i = 0; i < 8; i++) begin
      wr(`POC_ADDR_DLY_CH1 + 8'(i % 4), v[i]);
      rd_chk(`POC_ADDR_DLY_CH1 + 8'(i % 4), {v[i][7:2], 2'b00});
      chk("delay", 9'(chan_delay >> (9 * (3 - i % 4))),
        {v[i][7], v[i][7:2], 2'b00});
    end
    $display("delay test done");
  endtask
  task automatic t_modlim();
    for (int c = 0; c < 8; c++) begin
      wr(`POC_ADDR_MOD_LIMIT, 8'(c));
      rd_chk(`POC_ADDR_MOD_LIMIT, 8'(c));
      chk("mod_limit", mod_limit, 8'hfe - 8'(2 * c));
    end
    ce = 1'b0;
    wr(`POC_ADDR_MOD_LIMIT, 8'h02);
    ce = 1'b1;
    rd_chk(`POC_ADDR_MOD_LIMIT, 8'h07);
    $display("modulation test done");
  endtask
  task automatic t_group(input logic [7:0] g, input logic q, logic [3:0] r);
    wr(`POC_ADDR_STOP_GROUP, g);
    rd_chk(`POC_ADDR_STOP_GROUP, g);
    group_qualify = q;
    all_shutdown = 1'b1;
    repeat (3) @(negedge clk);
    chk("stage_on", stage_on, 4'h0);
    all_shutdown = 1'b0;
    repeat (3) @(negedge clk);
    chk("stage_on", stage_on, r);
    $display("group test done");
  endtask
  task automatic t_ramp(input logic [2:0] code, input int f, n, s);
    int len;
    len = 0;
    wr(`POC_ADDR_VOL_RAMP, {5'h00, code});
    rd_chk(`POC_ADDR_VOL_RAMP, {5'h00, code});
    rate_fam = poc_pkg::poc_rate_fam_t'(f[1:0]);
    vol_target = vol_target ^ 10'h2a5;
    @(negedge clk);
    chk("ramp_busy", ramp_busy, 1'b1);
    while (ramp_busy === 1'b1 && len < 10000) begin
      @(negedge clk);
      len++;
      // Half the steps taken: halfway between the two levels, floored
      if (len == n * s / 2) chk("ramp_mid", gain_applied, 10'h152);
    end
    chk("ramp_len", len >= (n - 1) * s + 1 && len <= n * s, 1'b1);
    chk("gain", gain_applied, vol_target);
    $display("ramp test done");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_delay();
    t_modlim();
    t_group(8'h3a, 1'b0, 4'h5);
    t_group(8'h3a, 1'b1, 4'hf);
    t_group(8'h30, 1'b0, 4'hf);
    t_ramp(3'h0, 0, 512, 4);
    t_ramp(3'h1, 1, 1024, 3);
    t_ramp(3'h2, 2, 2048, 2);
    t_ramp(3'h3, 0, 256, 4);
    t_ramp(3'h0, 2, 512, 2);
    give_verdict();
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule
